// file: src/reg_ctl_pkg.sv
// Shared constants and carrier types for the regulator control block
package reg_ctl_pkg;

  // Register index map
  localparam logic [7:0] REG_OUTPUT_CONTROL     = 8'h00;
  localparam logic [7:0] REG_PROTECTION_CONTROL = 8'h01;
  localparam logic [7:0] REG_FAULT_STATUS       = 8'h02;
  localparam logic [7:0] REG_DEVICE_IDENTITY    = 8'h03;

  // Arbitrary identity value, not tied to any product
  localparam logic [7:0] IDENTITY_VALUE = 8'h5a;

  // Field layout and reset values
  localparam logic [2:0] VSEL_DISABLED            = 3'h7;
  localparam logic [7:0] OUTPUT_CONTROL_RESET     = 8'h07;
  localparam logic [7:0] PROTECTION_CONTROL_RESET = 8'h00;
  localparam logic [7:0] READ_UNMAPPED            = 8'h00;
  localparam int         VSEL_MSB                 = 2;
  localparam int         UPPER_LSB                = 3;
  localparam int         LATCH_MODE_BIT           = 0;
  localparam int         NUM_IRQ_FAULTS           = 4;

  // Slave address base; the strap adds 0 to 3
  localparam logic [6:0] SLAVE_ADDR_BASE = 7'h08;

  // Bit counter points
  localparam logic [3:0] BIT_CNT_ZERO = 4'h0;
  localparam logic [3:0] BIT_CNT_ONE  = 4'h1;
  localparam logic [3:0] BIT_CNT_LSB  = 4'h7;
  localparam logic [3:0] BIT_CNT_ACK  = 4'h8;

  // Timing
  localparam int         CLK_FREQ_MHZ      = 100;
  localparam int         MAX_BIT_RATE_KBPS = 400;
  localparam int         START_HOLD_NS     = 200;
  localparam int         START_HOLD_CYCLES = (START_HOLD_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam logic [4:0] START_HOLD_COUNT  = 5'(START_HOLD_CYCLES);
  localparam logic [4:0] HOLD_LAST         = 5'h01;
  localparam logic [4:0] HOLD_NONE         = 5'h00;

  typedef struct packed {
    logic sink_timeout;
    logic power_good;
    logic over_current;
    logic uvlo;
    logic over_voltage;
    logic over_temp;
  } fault_cond_t;

  typedef struct packed {
    logic        scl;
    logic        sda;
    fault_cond_t fault;
    logic        wr_strobe;
    logic        rd_strobe;
  } sync_in_t;

  typedef struct packed {
    logic       strobe;
    logic       is_data;
    logic [7:0] value;
  } link_msg_t;

  typedef enum logic [4:0] {
    PH_ADDR   = 5'h01,
    PH_REG    = 5'h02,
    PH_WDATA  = 5'h04,
    PH_RDATA  = 5'h08,
    PH_IGNORE = 5'h10
  } link_phase_t;

  typedef struct packed {
    link_phase_t phase;
    logic        begun;
    logic [3:0]  cnt;
    logic [7:0]  shreg;
    logic [7:0]  tx;
    logic        drive_low;
    link_msg_t   wr;
    logic        rd_strobe;
  } link_state_t;

  typedef struct packed {
    logic       prev_scl;
    logic       prev_sda;
    logic       frame_idle;
    logic [4:0] hold;
    logic [7:0] pointer;
    logic [7:0] output_control;
    logic [7:0] protection_control;
    logic [7:0] read_byte;
    logic [6:0] slave_addr;
    logic       strap_done;
    logic       wr_seen;
    logic       rd_seen;
    logic       irq_low;
    logic       stage_enable;
  } core_state_t;

  typedef struct packed {
    logic cond_prev;
    logic flag;
  } flag_state_t;

endpackage

// file: src/pin_sync3.sv
// Three-stage input synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module pin_sync3 #(
  parameter int WIDTH = 1
) (
  // Clock and control
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             ce,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] out;
  } sync_state_t;

  sync_state_t s;
  sync_state_t next_s;

  always_comb begin
    next_s    = s;
    next_s.s1 = async_in;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (s.s2[i] == s.s3[i]) begin
        next_s.out[i] = s.s3[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign sync_out = s.out;

endmodule

// file: src/fault_flag.sv
// Sticky fault status bit with read-to-clear held off while the condition stands
`timescale 1ns/1ps
module fault_flag (
  // Clock and control
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic ce,
  // Condition and read event
  input  wire logic cond,
  input  wire logic read_evt,
  // Status
  output logic      flag,
  output logic      rise
);

  reg_ctl_pkg::flag_state_t s;
  reg_ctl_pkg::flag_state_t next_s;

  always_comb begin
    next_s           = s;
    next_s.cond_prev = cond;
    rise             = cond && !s.cond_prev;
    // Set wins over a read in the same cycle
    if (rise || cond) begin
      next_s.flag = 1'b1;
    end else if (read_evt) begin
      next_s.flag = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign flag = s.flag;

endmodule

// file: src/regulator_i2c_fault_control.sv
// Regulator control: serial slave on the link clock, registers and fault sequencing
`timescale 1ns/1ps
module regulator_i2c_fault_control (
  // Core clock and control
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       ce,
  // Serial link; scl is also the clock of the link-facing logic
  input  wire logic       scl,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_b,
  // Address strap
  input  wire logic [1:0] addr_sel,
  // Fault conditions from the analog side
  input  wire logic       over_temp_in,
  input  wire logic       over_voltage_in,
  input  wire logic       uvlo_in,
  input  wire logic       over_current_in,
  input  wire logic       power_good_in,
  input  wire logic       sink_timeout_in,
  // Power stage control
  output logic [2:0]      vsel,
  output logic            stage_enable,
  // Open-drain interrupt
  output logic            irq_out,
  output logic            irq_oe_b
);

  reg_ctl_pkg::core_state_t  s;
  reg_ctl_pkg::core_state_t  next_s;
  reg_ctl_pkg::link_state_t  ls;
  reg_ctl_pkg::link_state_t  next_ls;
  reg_ctl_pkg::sync_in_t     raw_in;
  reg_ctl_pkg::sync_in_t     syn;
  reg_ctl_pkg::fault_cond_t  cond;

  logic [reg_ctl_pkg::NUM_IRQ_FAULTS-1:0] flags;
  logic [reg_ctl_pkg::NUM_IRQ_FAULTS-1:0] rises;

  logic sda_bit;
  logic start_seen;
  logic stop_seen;
  logic wr_now;
  logic rd_now;
  logic thermal_latch_mode;
  logic over_temp_flag;
  logic over_voltage_flag;
  logic uvlo_flag;
  logic over_current_flag;
  logic power_good_flag;
  logic sink_timeout_flag;
  logic [7:0] fault_status;

  // Pins and link strobes cross into the core domain
  always_comb begin
    raw_in.scl                = scl;
    raw_in.sda                = sda_in;
    raw_in.fault.over_temp    = over_temp_in;
    raw_in.fault.over_voltage = over_voltage_in;
    raw_in.fault.uvlo         = uvlo_in;
    raw_in.fault.over_current = over_current_in;
    raw_in.fault.power_good   = power_good_in;
    raw_in.fault.sink_timeout = sink_timeout_in;
    raw_in.wr_strobe          = ls.wr.strobe;
    raw_in.rd_strobe          = ls.rd_strobe;
  end

  pin_sync3 #(
    .WIDTH($bits(reg_ctl_pkg::sync_in_t))
  ) u_sync (
    .clk      (clk),
    .rst_b    (rst_b),
    .ce       (ce),
    .async_in (raw_in),
    .sync_out (syn)
  );

  assign cond = syn.fault;

  // Sticky status for the interrupting faults
  generate
    for (genvar g = 0; g < reg_ctl_pkg::NUM_IRQ_FAULTS; g++) begin : g_flag
      fault_flag u_flag (
        .clk      (clk),
        .rst_b    (rst_b),
        .ce       (ce),
        .cond     (cond[g]),
        .read_evt (rd_now),
        .flag     (flags[g]),
        .rise     (rises[g])
      );
    end
  endgenerate

  assign over_temp_flag     = flags[0];
  assign over_voltage_flag  = flags[1];
  assign uvlo_flag          = flags[2];
  assign over_current_flag  = flags[3];
  // Live bits, no interrupt
  assign power_good_flag    = cond.power_good;
  assign sink_timeout_flag  = cond.sink_timeout;
  assign fault_status       = {2'h0, sink_timeout_flag, power_good_flag, over_current_flag,
                               uvlo_flag, over_voltage_flag, over_temp_flag};
  assign thermal_latch_mode = s.protection_control[reg_ctl_pkg::LATCH_MODE_BIT];

  // Core domain: framing, registers, fault sequencing
  always_comb begin
    next_s          = s;
    next_s.prev_scl = syn.scl;
    next_s.prev_sda = syn.sda;
    start_seen      = syn.scl && s.prev_scl && s.prev_sda && !syn.sda;
    stop_seen       = syn.scl && s.prev_scl && !s.prev_sda && syn.sda;
    wr_now          = syn.wr_strobe && !s.wr_seen;
    rd_now          = syn.rd_strobe && !s.rd_seen;
    next_s.wr_seen  = syn.wr_strobe;
    next_s.rd_seen  = syn.rd_strobe;

    // Strap is caught once after reset release
    if (!s.strap_done) begin
      next_s.slave_addr = reg_ctl_pkg::SLAVE_ADDR_BASE + {5'h00, addr_sel};
      next_s.strap_done = 1'b1;
    end

    // Start or repeated start clears the link logic briefly, well before scl falls
    if (s.hold != reg_ctl_pkg::HOLD_NONE) begin
      next_s.hold = s.hold - reg_ctl_pkg::HOLD_LAST;
    end
    if (start_seen) begin
      next_s.hold       = reg_ctl_pkg::START_HOLD_COUNT;
      next_s.frame_idle = 1'b1;
    end else if (stop_seen) begin
      next_s.frame_idle = 1'b1;
    end else if (s.hold == reg_ctl_pkg::HOLD_LAST) begin
      next_s.frame_idle = 1'b0;
    end

    // Read byte only changes while the link logic is held, so it is stable to scl
    if (s.frame_idle) begin
      case (s.pointer)
        reg_ctl_pkg::REG_OUTPUT_CONTROL:     next_s.read_byte = s.output_control;
        reg_ctl_pkg::REG_PROTECTION_CONTROL: next_s.read_byte = s.protection_control;
        reg_ctl_pkg::REG_FAULT_STATUS:       next_s.read_byte = fault_status;
        reg_ctl_pkg::REG_DEVICE_IDENTITY:    next_s.read_byte = reg_ctl_pkg::IDENTITY_VALUE;
        default:                             next_s.read_byte = reg_ctl_pkg::READ_UNMAPPED;
      endcase
    end

    // Payload is held by the link until the next byte, so it is stable here
    if (wr_now) begin
      if (!ls.wr.is_data) begin
        next_s.pointer = ls.wr.value;
      end else begin
        case (s.pointer)
          reg_ctl_pkg::REG_OUTPUT_CONTROL: begin
            next_s.output_control[7:reg_ctl_pkg::UPPER_LSB] =
              ls.wr.value[7:reg_ctl_pkg::UPPER_LSB];
            if (!(thermal_latch_mode && cond.over_temp)) begin
              next_s.output_control[reg_ctl_pkg::VSEL_MSB:0] =
                ls.wr.value[reg_ctl_pkg::VSEL_MSB:0];
            end
          end
          reg_ctl_pkg::REG_PROTECTION_CONTROL: begin
            next_s.protection_control = ls.wr.value;
          end
          default: begin
          end
        endcase
      end
    end

    // Latch-off overrides a write in the same cycle; auto mode keeps the field
    if (thermal_latch_mode && rises[0]) begin
      next_s.output_control[reg_ctl_pkg::VSEL_MSB:0] = reg_ctl_pkg::VSEL_DISABLED;
    end

    // A new fault wins over the releasing read
    if (|rises) begin
      next_s.irq_low = 1'b1;
    end else if (rd_now) begin
      next_s.irq_low = 1'b0;
    end

    next_s.stage_enable =
      (next_s.output_control[reg_ctl_pkg::VSEL_MSB:0] != reg_ctl_pkg::VSEL_DISABLED) &&
      !cond.over_temp;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s                    <= '0;
      s.frame_idle         <= 1'b1;
      s.output_control     <= reg_ctl_pkg::OUTPUT_CONTROL_RESET;
      s.protection_control <= reg_ctl_pkg::PROTECTION_CONTROL_RESET;
    end else if (ce) begin
      s <= next_s;
    end
  end

  // Link domain: data is sampled on the rising scl edge
  always_ff @(posedge scl or posedge s.frame_idle) begin
    if (s.frame_idle) begin
      sda_bit <= 1'b1;
    end else if (ce) begin
      sda_bit <= sda_in;
    end
  end

  // Link domain: state moves and the line is driven on the falling scl edge
  always_comb begin
    next_ls       = ls;
    next_ls.begun = 1'b1;
    if (!ls.begun) begin
      // Falling edge that completes the start condition
      next_ls.cnt       = reg_ctl_pkg::BIT_CNT_ZERO;
      next_ls.phase     = reg_ctl_pkg::PH_ADDR;
      next_ls.drive_low = 1'b0;
    end else if (ls.cnt == reg_ctl_pkg::BIT_CNT_ACK) begin
      // End of the acknowledge slot
      next_ls.cnt       = reg_ctl_pkg::BIT_CNT_ZERO;
      next_ls.drive_low = 1'b0;
      next_ls.wr.strobe = 1'b0;
      next_ls.rd_strobe = 1'b0;
      if (ls.phase == reg_ctl_pkg::PH_RDATA) begin
        if (sda_bit) begin
          next_ls.phase = reg_ctl_pkg::PH_IGNORE;
        end else begin
          next_ls.tx        = s.read_byte;
          next_ls.drive_low = !s.read_byte[7];
        end
      end
    end else begin
      next_ls.cnt   = ls.cnt + reg_ctl_pkg::BIT_CNT_ONE;
      next_ls.shreg = {ls.shreg[6:0], sda_bit};
      if (ls.phase == reg_ctl_pkg::PH_RDATA) begin
        next_ls.tx        = {ls.tx[6:0], 1'b0};
        next_ls.drive_low = !ls.tx[6];
      end
      if (ls.cnt == reg_ctl_pkg::BIT_CNT_LSB) begin
        next_ls.drive_low = 1'b0;
        case (ls.phase)
          reg_ctl_pkg::PH_ADDR: begin
            // General call never matches the strapped address
            if (ls.shreg[6:0] == s.slave_addr) begin
              next_ls.drive_low = 1'b1;
              next_ls.phase     = reg_ctl_pkg::PH_REG;
              if (sda_bit) begin
                next_ls.phase = reg_ctl_pkg::PH_RDATA;
              end
            end else begin
              next_ls.phase = reg_ctl_pkg::PH_IGNORE;
            end
          end
          reg_ctl_pkg::PH_REG: begin
            next_ls.drive_low = 1'b1;
            next_ls.wr        = '{strobe: 1'b1, is_data: 1'b0,
                                  value: {ls.shreg[6:0], sda_bit}};
            next_ls.phase     = reg_ctl_pkg::PH_WDATA;
          end
          reg_ctl_pkg::PH_WDATA: begin
            next_ls.drive_low = 1'b1;
            next_ls.wr        = '{strobe: 1'b1, is_data: 1'b1,
                                  value: {ls.shreg[6:0], sda_bit}};
          end
          reg_ctl_pkg::PH_RDATA: begin
            next_ls.rd_strobe = 1'b1;
          end
          reg_ctl_pkg::PH_IGNORE: begin
          end
          default: begin
            next_ls.phase = reg_ctl_pkg::PH_IGNORE;
          end
        endcase
      end
    end
  end

  // Held clear between frames; works regardless of the stage state
  always_ff @(negedge scl or posedge s.frame_idle) begin
    if (s.frame_idle) begin
      ls       <= '0;
      ls.phase <= reg_ctl_pkg::PH_ADDR;
    end else if (ce) begin
      ls <= next_ls;
    end
  end

  // Outputs
  assign sda_out      = 1'b0;
  assign sda_oe_b     = !ls.drive_low;
  assign irq_out      = 1'b0;
  assign irq_oe_b     = !s.irq_low;
  assign vsel         = s.output_control[reg_ctl_pkg::VSEL_MSB:0];
  assign stage_enable = s.stage_enable;

endmodule

// file: dv/reg_ctl_chk.sv
// Port-level checks for the regulator control block
`timescale 1ns/1ps
module reg_ctl_chk (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst_b,
  // Link and faults
  input wire logic       scl,
  input wire logic       sda_oe_b,
  input wire logic       over_temp_in,
  input wire logic       over_voltage_in,
  input wire logic       uvlo_in,
  input wire logic       over_current_in,
  // Stage and interrupt
  input wire logic [2:0] vsel,
  input wire logic       stage_enable,
  input wire logic       irq_oe_b
);
  logic [3:0] ot_age;
  logic [3:0] next_ot_age;

  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // Cycles since over-temperature was last high, saturating
  always_comb begin
    next_ot_age = ot_age;
    if (over_temp_in) begin
      next_ot_age = 4'h0;
    end else if (ot_age != 4'hf) begin
      next_ot_age = ot_age + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ot_age <= 4'hf;
    end else begin
      ot_age <= next_ot_age;
    end
  end

  sequence s_ot_held;
    over_temp_in [*8];
  endsequence

  sequence s_irq_quiet;
    (irq_oe_b && !over_temp_in && !over_voltage_in && !uvlo_in && !over_current_in) [*8];
  endsequence

  property p_ot_off;
    s_ot_held |-> !stage_enable;
  endproperty
  a_ot_off: assert property (p_ot_off)
    else $error("stage on during over-temperature");

  property p_vsel_off;
    (vsel == 3'h7) [*2] |-> !stage_enable;
  endproperty
  a_vsel_off: assert property (p_vsel_off)
    else $error("stage on with disable code");

  property p_enable;
    (vsel != 3'h7 && !over_temp_in) [*8] |-> stage_enable;
  endproperty
  a_enable: assert property (p_enable)
    else $error("stage off with valid code");

  property p_irq_ot;
    $rose(over_temp_in) |-> ##[1:8] !irq_oe_b;
  endproperty
  a_irq_ot: assert property (p_irq_ot)
    else $error("no interrupt on over-temperature");

  property p_irq_ov;
    $rose(over_voltage_in) |-> ##[1:8] !irq_oe_b;
  endproperty
  a_irq_ov: assert property (p_irq_ov)
    else $error("no interrupt on over-voltage");

  property p_irq_quiet;
    s_irq_quiet |=> irq_oe_b;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet)
    else $error("interrupt without cause");

  property p_sda_edge;
    !$stable(sda_oe_b) |-> !scl;
  endproperty
  a_sda_edge: assert property (p_sda_edge)
    else $error("data changed while clock high");

  // Lag of one cycle after the code leaves the disable value 3'h7 is allowed
  property p_off_cause;
    !stage_enable && vsel != 3'h7 && $past(vsel) != 3'h7 |-> ot_age < 4'hc;
  endproperty
  a_off_cause: assert property (p_off_cause)
    else $error("stage off without cause");
endmodule

bind regulator_i2c_fault_control reg_ctl_chk reg_ctl_chk_inst (
  .clk(clk), .rst_b(rst_b), .scl(scl), .sda_oe_b(sda_oe_b),
  .over_temp_in(over_temp_in), .over_voltage_in(over_voltage_in), .uvlo_in(uvlo_in),
  .over_current_in(over_current_in), .vsel(vsel), .stage_enable(stage_enable),
  .irq_oe_b(irq_oe_b)
);

// file: dv/i2c_host_model.sv
// Host controller model driving the serial link as master
`timescale 1ns/1ps
module i2c_host_model (
  // Device side of the data line
  input  wire logic sda_oe_b,
  // Link
  output logic      scl,
  output logic      sda_line
);
  // 4 x 42 x 15 ns per bit keeps the rate just under 400 kbps
  localparam int QUARTER = 42;
  logic tick;
  logic host_low;

  initial begin
    tick = 1'b0;
    host_low = 1'b0;
    scl = 1'b1;
  end

  // Link timebase, off the core clock grid on purpose
  always #7.5 tick = ~tick;

  // Pull-up wins unless a party pulls low
  assign sda_line = ~(host_low | ~sda_oe_b);

  task automatic wait_q();
    repeat (QUARTER) @(posedge tick);
  endtask

  task automatic start();
    if (!scl) begin
      host_low <= 1'b0;
      wait_q();
      scl <= 1'b1;
      wait_q();
    end
    host_low <= 1'b1;
    wait_q();
    wait_q();
    scl <= 1'b0;
    wait_q();
  endtask

  task automatic bit_io(input logic b, output logic seen);
    host_low <= ~b;
    wait_q();
    scl <= 1'b1;
    wait_q();
    seen = sda_line;
    wait_q();
    scl <= 1'b0;
    wait_q();
  endtask

  task automatic byte_io(input logic [7:0] tx, input logic ack_in,
                         output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(ack_in, ack);
  endtask

  task automatic stop();
    host_low <= 1'b1;
    wait_q();
    scl <= 1'b1;
    wait_q();
    host_low <= 1'b0;
    wait_q();
  endtask
endmodule

// file: dv/testbench.sv
// Self-checking bench for the regulator control block
`timescale 1ns/1ps
module testbench;
  localparam logic [6:0] DEV = reg_ctl_pkg::SLAVE_ADDR_BASE + 7'h1;
  localparam logic [7:0] OC = reg_ctl_pkg::REG_OUTPUT_CONTROL;
  localparam logic [7:0] FS = reg_ctl_pkg::REG_FAULT_STATUS;
  logic       clk = 1'b0;
  logic       rst_b = 1'b0;
  logic [5:0] flt = 6'h00;
  logic       scl;
  logic       sda_out;
  logic       irq_out;
  logic       sda_line;
  logic       sda_oe_b;
  logic       irq_oe_b;
  logic       stage_enable;
  logic [2:0] vsel;
  logic [7:0] rd;
  int         failures = 0;
  int         total_checks = 0;

  always #5 clk = ~clk;

  // Strap selects base plus one; every fault input has its own bench bit
  regulator_i2c_fault_control regulator_i2c_fault_control_inst (
    .clk(clk), .rst_b(rst_b), .ce(1'b1), .scl(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_b(sda_oe_b), .addr_sel(2'h1),
    .over_temp_in(flt[0]), .over_voltage_in(flt[1]), .uvlo_in(flt[3]),
    .over_current_in(flt[4]), .power_good_in(flt[2]), .sink_timeout_in(flt[5]),
    .vsel(vsel), .stage_enable(stage_enable), .irq_out(irq_out), .irq_oe_b(irq_oe_b)
  );

  i2c_host_model i2c_host_model_inst (.sda_oe_b(sda_oe_b), .scl(scl), .sda_line(sda_line));

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [7:0] pins();
    return {irq_out, sda_out, vsel, stage_enable, irq_oe_b, sda_oe_b};
  endfunction

  function automatic logic [7:0] ex(input logic [2:0] v, input logic se, input logic irq);
    return {2'h0, v, se, irq, 1'b1};
  endfunction

  task automatic write_reg(input logic [7:0] r, input logic [7:0] d);
    logic [7:0] rx;
    logic       a0;
    logic       a1;
    logic       a2;
    i2c_host_model_inst.start();
    i2c_host_model_inst.byte_io({DEV, 1'b0}, 1'b1, rx, a0);
    i2c_host_model_inst.byte_io(r, 1'b1, rx, a1);
    i2c_host_model_inst.byte_io(d, 1'b1, rx, a2);
    i2c_host_model_inst.stop();
    chk("write ack", 8'h00, {5'h0, a0, a1, a2});
  endtask

  // Optional pointer write, then repeated start and one byte read
  task automatic read_reg(input logic [7:0] r, input logic set_ptr, output logic [7:0] d);
    logic [7:0] rx;
    logic       a0;
    logic       a1;
    logic       a2;
    logic       a3;
    a0 = 1'b0;
    a1 = 1'b0;
    i2c_host_model_inst.start();
    if (set_ptr) begin
      i2c_host_model_inst.byte_io({DEV, 1'b0}, 1'b1, rx, a0);
      i2c_host_model_inst.byte_io(r, 1'b1, rx, a1);
      i2c_host_model_inst.start();
    end
    i2c_host_model_inst.byte_io({DEV, 1'b1}, 1'b1, rx, a2);
    i2c_host_model_inst.byte_io(8'hff, 1'b1, d, a3);
    i2c_host_model_inst.stop();
    chk("read ack", 8'h00, {5'h0, a0, a1, a2});
  endtask

  task automatic probe(input logic [6:0] a);
    logic [7:0] rx;
    logic       ak;
    i2c_host_model_inst.start();
    i2c_host_model_inst.byte_io({a, 1'b0}, 1'b1, rx, ak);
    i2c_host_model_inst.stop();
    chk("foreign ack", 8'h01, {7'h0, ak});
  endtask

  // Margin covers the three-flop sync of fault inputs
  task automatic set_flt(input logic [5:0] v);
    @(posedge clk);
    flt <= v;
    repeat (12) @(posedge clk);
  endtask

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask

  task automatic stop_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    // Run needs about 93000 cycles at the host model's bit rate, just under 400 kbps
    repeat (99000) @(posedge clk);
    failures++;
    stop_test();
  end

  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (10) @(posedge clk);
    chk("reset pins", ex(3'h7, 1'b0, 1'b1), pins());
    read_reg(reg_ctl_pkg::REG_DEVICE_IDENTITY, 1'b1, rd);
    chk("identity", reg_ctl_pkg::IDENTITY_VALUE, rd);
    read_reg(8'h04, 1'b1, rd);
    chk("unmapped", reg_ctl_pkg::READ_UNMAPPED, rd);
    probe(reg_ctl_pkg::SLAVE_ADDR_BASE);
    probe(7'h00);
    end_test("access");
    write_reg(OC, 8'h03);
    chk("enabled", ex(3'h3, 1'b1, 1'b1), pins());
    set_flt(6'h01);
    chk("auto trip", ex(3'h3, 1'b0, 1'b0), pins());
    read_reg(FS, 1'b1, rd);
    chk("status trip", 8'h01, rd);
    chk("irq read", ex(3'h3, 1'b0, 1'b1), pins());
    set_flt(6'h00);
    chk("auto back", ex(3'h3, 1'b1, 1'b1), pins());
    read_reg(FS, 1'b0, rd);
    chk("status held", 8'h01, rd);
    read_reg(FS, 1'b0, rd);
    chk("status clear", 8'h00, rd);
    end_test("auto thermal");
    write_reg(reg_ctl_pkg::REG_PROTECTION_CONTROL, 8'h01);
    set_flt(6'h01);
    chk("latch trip", ex(3'h7, 1'b0, 1'b0), pins());
    write_reg(OC, 8'h03);
    chk("write ignored", ex(3'h7, 1'b0, 1'b0), pins());
    set_flt(6'h00);
    chk("stays off", ex(3'h7, 1'b0, 1'b0), pins());
    write_reg(OC, 8'h05);
    chk("rewritten", ex(3'h5, 1'b1, 1'b0), pins());
    read_reg(FS, 1'b1, rd);
    chk("status latch", 8'h01, rd);
    end_test("latch thermal");
    set_flt(6'h04);
    chk("good no irq", ex(3'h5, 1'b1, 1'b1), pins());
    set_flt(6'h06);
    chk("ov irq", ex(3'h5, 1'b1, 1'b0), pins());
    read_reg(FS, 1'b0, rd);
    chk("status ov", 8'h12, rd);
    chk("irq ov read", ex(3'h5, 1'b1, 1'b1), pins());
    set_flt(6'h26);
    chk("timeout no irq", ex(3'h5, 1'b1, 1'b1), pins());
    set_flt(6'h18);
    chk("uv oc irq", ex(3'h5, 1'b1, 1'b0), pins());
    read_reg(FS, 1'b0, rd);
    chk("status uv oc", 8'h0e, rd);
    chk("irq uv oc read", ex(3'h5, 1'b1, 1'b1), pins());
    end_test("interrupts");
    stop_test();
  end
endmodule
